// ### logic/bism_map.vh
/*
 * Register map, field positions and reset values of the bridge interrupt
 * status and routing block. Definitions only; included by the design files.
 * Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
 */
`ifndef BISM_MAP_VH
`define BISM_MAP_VH

// Register byte offsets
`define BISM_OFS_MISC_ROUTING 12'h300
`define BISM_OFS_STATUS 12'h304
`define BISM_OFS_LEVEL_ROUTING 12'h308
`define BISM_OFS_VME_ENABLE 12'h310
`define BISM_OFS_LOCAL_MASK 12'h320
`define BISM_OFS_VME_SW_STATUS 12'h324
`define BISM_ADDR_BITS 12

// Writable-bit masks; everything else is reserved
`define BISM_MASK_MISC_ROUTING 32'h7777_0777
`define BISM_MASK_LEVEL_ROUTING 32'h7777_7777
`define BISM_MASK_VME_ENABLE 32'hfe0f_17ff
`define BISM_MASK_STATUS 32'h00ff_f7ff
`define BISM_MASK_VME_SW_STATUS 32'hfe00_1000

// Reset values
`define BISM_RST_WORD 32'h0000_0000
`define BISM_RST_PINS 8'h00

// Status and mask bit positions
`define BISM_BIT_OWNERSHIP 0
`define BISM_BIT_LEVEL1 1
`define BISM_BIT_DMA 8
`define BISM_BIT_LOCAL_ERR 9
`define BISM_BIT_VME_ERR 10
`define BISM_BIT_SW_ACK 12
`define BISM_BIT_SOFTWARE_INTERRUPT 13
`define BISM_BIT_SYS_FAIL 14
`define BISM_BIT_AC_FAIL 15
`define BISM_BIT_MAILBOX0 16
`define BISM_BIT_LOCMON0 20
`define BISM_SOURCES 24

// Routing field low bits in the misc routing register
`define BISM_FLD_AC_FAIL 28
`define BISM_FLD_SYS_FAIL 24
`define BISM_FLD_SOFTWARE_INTERRUPT 20
`define BISM_FLD_SW_ACK 16
`define BISM_FLD_VME_ERR 8
`define BISM_FLD_LOCAL_ERR 4
`define BISM_FLD_DMA 0
`define BISM_FLD_W 3

// VME enable register positions
`define BISM_VEN_LEVEL1 25
`define BISM_VEN_SOFTWARE_INTERRUPT 12

// Synchroniser depth for pins
`define BISM_SYNC_STAGES 3

`endif

// ### logic/bism_sync.v
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk; output moves only once the
 * second and third stages agree.
 */
`timescale 1ns/10ps
`include "bism_map.vh"

module bism_sync #(
    parameter WIDTH = 9
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out
);

reg [WIDTH-1:0] stage_one;
reg [WIDTH-1:0] stage_two;
reg [WIDTH-1:0] stage_three;
integer i;

// Stage one is read by stage two only, to contain metastability
always @(posedge clk or posedge rst) begin
    if (rst) begin
        stage_one <= {WIDTH{1'b0}};
        stage_two <= {WIDTH{1'b0}};
        stage_three <= {WIDTH{1'b0}};
        level_out <= {WIDTH{1'b0}};
    end else if (ce) begin
        stage_one <= pin_in;
        stage_two <= stage_one;
        stage_three <= stage_two;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage_two[i] == stage_three[i]) begin
                level_out[i] <= stage_three[i];
            end
        end
    end
end

endmodule

// ### logic/bism_top.v
/*
 * Interrupt status latching, routing to eight local pins, and the
 * VME-side software interrupt enables of a bus bridge.
 * Assumes an AHB-Lite master on the same clock, event inputs from
 * logic on clk, and failure/level lines arriving straight from pins.
 */
`timescale 1ns/10ps
`include "bism_map.vh"

module bism_top (
    input wire clk,
    input wire rst,
    input wire ce,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Event sources from logic on clk
    input wire [3:0] mailbox_events,
    input wire [3:0] location_monitor_events,
    input wire software_acknowledge_event,
    input wire vme_error_event,
    input wire local_bus_error_event,
    input wire dma_done_event,
    input wire bus_ownership_granted,
    input wire [7:1] acknowledge_done,
    // Pins from the VMEbus
    input wire ac_fail_pin,
    input wire sys_fail_pin,
    input wire [7:1] vme_request_levels,
    // Outputs
    output reg [7:1] acknowledge_request,
    output reg [7:0] local_interrupt_pins,
    output reg [7:1] vme_software_levels,
    output reg vme_software_interrupt
);

// Register bus state
reg wr_pending;
reg rd_pending;
reg [`BISM_ADDR_BITS-1:0] bus_addr;

// Software-visible registers
reg [31:0] misc_source_routing;
reg [31:0] vme_level_routing;
reg [31:0] vme_side_interrupt_enable;
reg [31:0] local_interrupt_mask;
reg [31:0] local_interrupt_status;
reg [31:0] vme_software_status;

// Event edge history
reg [`BISM_SOURCES-1:0] event_prev;

wire [8:0] pins_synced;
wire ac_fail_level;
wire sys_fail_level;
wire [7:1] level_lines;

// Failure and request lines cross in from the VMEbus
// Only the agreed level is used, so a one-clock pin glitch never sets status
bism_sync #(
    .WIDTH(9)
) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin_in({ac_fail_pin, sys_fail_pin, vme_request_levels}),
    .level_out(pins_synced)
);

assign ac_fail_level = pins_synced[8];
assign sys_fail_level = pins_synced[7];
assign level_lines = pins_synced[6:0];

// Bus phase decode
// Limitation: only address bits 11:2 decode, so the map repeats every 4 KB
wire addr_phase;
wire wr_now;
reg [31:0] wr_data;

assign addr_phase = hsel && htrans[1] && hready;
assign wr_now = wr_pending;

// Write strobes per register, data limited to writable bits
wire wr_misc;
wire wr_level;
wire wr_ven;
wire wr_mask;
wire wr_stat;
wire wr_vsw;

assign wr_misc = wr_now && (bus_addr == `BISM_OFS_MISC_ROUTING);
assign wr_level = wr_now && (bus_addr == `BISM_OFS_LEVEL_ROUTING);
assign wr_ven = wr_now && (bus_addr == `BISM_OFS_VME_ENABLE);
assign wr_mask = wr_now && (bus_addr == `BISM_OFS_LOCAL_MASK);
assign wr_stat = wr_now && (bus_addr == `BISM_OFS_STATUS);
assign wr_vsw = wr_now && (bus_addr == `BISM_OFS_VME_SW_STATUS);

always @* begin
    wr_data = hwdata;
end

// Event vector laid out in status bit order
wire [`BISM_SOURCES-1:0] event_now;
wire [`BISM_SOURCES-1:0] event_rise;

assign event_now = {location_monitor_events, mailbox_events,
                    1'b0, 1'b0, 1'b0, software_acknowledge_event,
                    1'b0, vme_error_event, local_bus_error_event, dma_done_event,
                    acknowledge_done, bus_ownership_granted};
assign event_rise = event_now & ~event_prev;

// Local software interrupt fires on a mask bit going zero to one
wire software_interrupt_rise;
assign software_interrupt_rise = wr_mask && wr_data[`BISM_BIT_SOFTWARE_INTERRUPT] && !local_interrupt_mask[`BISM_BIT_SOFTWARE_INTERRUPT];

// Status next value: sets win over the same-cycle clear
reg [31:0] next_status;
reg [31:0] stat_clear;
always @* begin
    stat_clear = wr_stat ? (wr_data & `BISM_MASK_STATUS) : `BISM_RST_WORD;
    next_status = local_interrupt_status & ~stat_clear;
    next_status[`BISM_SOURCES-1:0] = next_status[`BISM_SOURCES-1:0] | event_rise;
    if (software_interrupt_rise) begin
        next_status[`BISM_BIT_SOFTWARE_INTERRUPT] = 1'b1;
    end
    // Level-sensitive: pin held keeps the bit, clear only after release
    if (ac_fail_level) begin
        next_status[`BISM_BIT_AC_FAIL] = 1'b1;
    end
    if (sys_fail_level) begin
        next_status[`BISM_BIT_SYS_FAIL] = 1'b1;
    end
    next_status = next_status & `BISM_MASK_STATUS;
end

// VME software levels: rising enable bits set sticky status
// Mailbox, error and pin enable bits are plain storage with no edge logic
wire [31:0] ven_write;
wire [31:0] ven_rise;
reg [31:0] next_vsw;
assign ven_write = wr_data & `BISM_MASK_VME_ENABLE;
assign ven_rise = wr_ven ? (ven_write & ~vme_side_interrupt_enable & `BISM_MASK_VME_SW_STATUS) : `BISM_RST_WORD;

always @* begin
    next_vsw = vme_software_status;
    if (wr_vsw) begin
        next_vsw = next_vsw & ~(wr_data & `BISM_MASK_VME_SW_STATUS);
    end
    next_vsw = next_vsw | ven_rise;
end

// Routing fields gathered per status bit; unroutable sources use pin 0
wire [3*`BISM_SOURCES-1:0] route_by_bit;
assign route_by_bit = {
    {8{3'b000}},
    misc_source_routing[`BISM_FLD_AC_FAIL +: 3],
    misc_source_routing[`BISM_FLD_SYS_FAIL +: 3],
    misc_source_routing[`BISM_FLD_SOFTWARE_INTERRUPT +: 3],
    misc_source_routing[`BISM_FLD_SW_ACK +: 3],
    3'b000,
    misc_source_routing[`BISM_FLD_VME_ERR +: 3],
    misc_source_routing[`BISM_FLD_LOCAL_ERR +: 3],
    misc_source_routing[`BISM_FLD_DMA +: 3],
    vme_level_routing[28 +: 3], vme_level_routing[24 +: 3],
    vme_level_routing[20 +: 3], vme_level_routing[16 +: 3],
    vme_level_routing[12 +: 3], vme_level_routing[8 +: 3],
    vme_level_routing[4 +: 3], vme_level_routing[0 +: 3]
};

// Active sources are latched and unmasked
wire [`BISM_SOURCES-1:0] source_active;
assign source_active = local_interrupt_status[`BISM_SOURCES-1:0]
                       & local_interrupt_mask[`BISM_SOURCES-1:0];

// Each source hits exactly the one pin its field names; the route code
// is widened to the genvar's width so the compare pads nothing silently
wire [8*`BISM_SOURCES-1:0] pin_hit;
wire [7:0] next_pins;
genvar gp;
genvar gs;
generate
    for (gp = 0; gp < 8; gp = gp + 1) begin : g_pin
        for (gs = 0; gs < `BISM_SOURCES; gs = gs + 1) begin : g_src
            assign pin_hit[gp*`BISM_SOURCES+gs] = source_active[gs]
                && ({29'h0, route_by_bit[3*gs +: 3]} == gp);
        end
        assign next_pins[gp] = |pin_hit[gp*`BISM_SOURCES +: `BISM_SOURCES];
    end
endgenerate

// Acknowledge request: enabled, line asserted, status not yet taken
// A set status bit blocks a second vector at that level until cleared
wire [7:1] next_ack_req;
assign next_ack_req = local_interrupt_mask[7:1] & level_lines
                      & ~local_interrupt_status[7:1];

// Read multiplexer, unmapped and reserved read as zero
reg [31:0] read_word;
always @* begin
    if (bus_addr == `BISM_OFS_MISC_ROUTING) begin
        read_word = misc_source_routing;
    end else if (bus_addr == `BISM_OFS_STATUS) begin
        read_word = local_interrupt_status;
    end else if (bus_addr == `BISM_OFS_LEVEL_ROUTING) begin
        read_word = vme_level_routing;
    end else if (bus_addr == `BISM_OFS_VME_ENABLE) begin
        read_word = vme_side_interrupt_enable;
    end else if (bus_addr == `BISM_OFS_LOCAL_MASK) begin
        read_word = local_interrupt_mask;
    end else if (bus_addr == `BISM_OFS_VME_SW_STATUS) begin
        read_word = vme_software_status;
    end else begin
        read_word = `BISM_RST_WORD;
    end
end

// Bus slave: writes zero-wait, reads take one wait state so that a
// write just before is already visible in the returned word.
// Limitation: with ce low the slave still shows ready but takes nothing,
// so a master must stay idle while the block is frozen
always @(posedge clk or posedge rst) begin
    if (rst) begin
        wr_pending <= 1'b0;
        rd_pending <= 1'b0;
        bus_addr <= {`BISM_ADDR_BITS{1'b0}};
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= `BISM_RST_WORD;
    end else if (ce) begin
        hresp <= 1'b0;
        if (rd_pending) begin
            hrdata <= read_word;
            hreadyout <= 1'b1;
            rd_pending <= 1'b0;
        end else begin
            wr_pending <= addr_phase && hwrite;
            if (addr_phase) begin
                bus_addr <= {haddr[`BISM_ADDR_BITS-1:2], 2'b00};
            end
            if (addr_phase && !hwrite) begin
                rd_pending <= 1'b1;
                hreadyout <= 1'b0;
            end
        end
    end
end

// Software registers and sticky status
// Writes keep only writable bits, so reserved positions read back zero
always @(posedge clk or posedge rst) begin
    if (rst) begin
        misc_source_routing <= `BISM_RST_WORD;
        vme_level_routing <= `BISM_RST_WORD;
        vme_side_interrupt_enable <= `BISM_RST_WORD;
        local_interrupt_mask <= `BISM_RST_WORD;
        local_interrupt_status <= `BISM_RST_WORD;
        vme_software_status <= `BISM_RST_WORD;
        event_prev <= {`BISM_SOURCES{1'b0}};
    end else if (ce) begin
        event_prev <= event_now;
        if (wr_misc) begin
            misc_source_routing <= wr_data & `BISM_MASK_MISC_ROUTING;
        end
        if (wr_level) begin
            vme_level_routing <= wr_data & `BISM_MASK_LEVEL_ROUTING;
        end
        if (wr_ven) begin
            vme_side_interrupt_enable <= ven_write;
        end
        if (wr_mask) begin
            local_interrupt_mask <= wr_data & `BISM_MASK_STATUS;
        end
        local_interrupt_status <= next_status;
        vme_software_status <= next_vsw;
    end
end

// Registered pins toward both buses
// One clock of latency after status, traded for glitch-free pins
always @(posedge clk or posedge rst) begin
    if (rst) begin
        local_interrupt_pins <= `BISM_RST_PINS;
        acknowledge_request <= 7'h00;
        vme_software_levels <= 7'h00;
        vme_software_interrupt <= 1'b0;
    end else if (ce) begin
        local_interrupt_pins <= next_pins;
        acknowledge_request <= next_ack_req;
        // Dropping the enable masks the request; status stays set
        vme_software_levels <= vme_software_status[31:25]
                               & vme_side_interrupt_enable[31:25];
        vme_software_interrupt <= vme_software_status[`BISM_VEN_SOFTWARE_INTERRUPT]
                                  & vme_side_interrupt_enable[`BISM_VEN_SOFTWARE_INTERRUPT];
    end
end

endmodule

// ### verification/bism_monitor.sv
/*
 * Port checker for the interrupt status and routing block.
 * Assumes one clock, async active-high reset, bound to the top module.
 */
`timescale 1ns/10ps
module bism_monitor (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire [7:1] acknowledge_done,
    input wire [7:1] vme_request_levels,
    input wire [7:1] acknowledge_request,
    input wire [7:0] local_interrupt_pins,
    input wire [7:1] vme_software_levels,
    input wire vme_software_interrupt
);
    logic [3:0] since_wr;
    logic [7:1] done_q;
    wire take = hsel && htrans[1] && hready && ce;
    wire [7:1] done_rise = acknowledge_done & ~done_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Saturating age of the last write, and last acknowledge lines
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            since_wr <= 4'hf;
            done_q <= 7'h0;
        end else begin
            done_q <= acknowledge_done;
            if (take && hwrite)
                since_wr <= 4'h0;
            else if (since_wr != 4'hf)
                since_wr <= since_wr + 4'h1;
        end
    end
    AST_RESET_OUTS: assert property (disable iff (1'h0)
        rst |-> hreadyout && local_interrupt_pins == 8'h0 && acknowledge_request == 7'h0)
        else $error("outputs not at reset values");
    AST_ALWAYS_OKAY: assert property (hresp == 1'h0) else $error("response not OKAY");
    AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    AST_RDATA_HOLD: assert property (!$rose(hreadyout) |-> $stable(hrdata))
        else $error("read data moved outside a read");
    AST_ACK_STOPS: assert property (|done_rise |->
        ##3 (acknowledge_request & $past(done_rise, 3)) == 7'h0) else $error("request after acknowledge");
    AST_ACK_NEEDS_LINE: assert property ((vme_request_levels == 7'h0) [*8] |->
        acknowledge_request == 7'h0) else $error("request without a level line");
    AST_SW_AFTER_WRITE: assert property ((|(vme_software_levels & ~$past(vme_software_levels))
        || $rose(vme_software_interrupt)) |-> since_wr <= 4'h5) else $error("software level rose unasked");
    cover property (local_interrupt_pins != 8'h0);
    cover property (|done_rise);
    cover property (vme_software_levels != 7'h0);
endmodule

bind bism_top bism_monitor u_monitor (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .acknowledge_done(acknowledge_done), .vme_request_levels(vme_request_levels),
    .acknowledge_request(acknowledge_request), .local_interrupt_pins(local_interrupt_pins),
    .vme_software_levels(vme_software_levels), .vme_software_interrupt(vme_software_interrupt));

// ### verification/bism_tb.sv
/*
 * Self-checking bench for the interrupt status and routing block.
 * Assumes the AHB-Lite slave is alone on the bus, so hready is its hreadyout.
 */
`timescale 1ns/10ps
`include "bism_map.vh"
module tb_top;
    logic clk = 1'h0, rst = 1'h0, hsel = 1'h0, hwrite = 1'h0, slow = 1'h0, ce = 1'h1;
    logic [1:0] htrans = 2'h0, fl = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv, d, hrdata;
    logic [6:0] src = 7'h0;
    logic [7:1] raise = 7'h0, ack_done, vme_lines, ack_req, sw_lv;
    logic hreadyout, hresp, software_interrupt;
    logic [7:0] pins;
    logic [31:0] ra[4] = '{32'h300, 32'h308, 32'h310, 32'h320};
    logic [31:0] rm[4] = '{`BISM_MASK_MISC_ROUTING, `BISM_MASK_LEVEL_ROUTING, `BISM_MASK_VME_ENABLE, 32'h00fff7ff};
    int n_errors = 0, compares = 0, i, k, p, b, t;
    always #5 clk = ~clk;
    bism_top dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mailbox_events({3'h0, src[4]}), .location_monitor_events({3'h0, src[6]}),
        .software_acknowledge_event(src[3]), .vme_error_event(src[2]), .local_bus_error_event(src[1]),
        .dma_done_event(src[0]), .bus_ownership_granted(src[5]), .acknowledge_done(ack_done), .ac_fail_pin(fl[1]),
        .sys_fail_pin(fl[0]), .vme_request_levels(vme_lines), .acknowledge_request(ack_req),
        .local_interrupt_pins(pins), .vme_software_levels(sw_lv), .vme_software_interrupt(software_interrupt));
    bism_vme_model vme (.clk(clk), .rst(rst), .raise(raise), .slow(slow), .acknowledge_request(ack_req),
        .acknowledge_done(ack_done), .vme_request_levels(vme_lines));
    // Status bit of each bench event source, and misc routing field of the first four
    function automatic int sbit(int n);
        int v[7] = '{8, 9, 10, 12, 16, 0, 20};
        return v[n];
    endfunction
    function automatic int fpos(int n);
        int v[4] = '{0, 4, 8, 16};
        return v[n];
    endfunction
    // One single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rdv = hrdata;
    endtask
    task automatic chk(logic [31:0] a, logic [31:0] e);
        bus(1'h0, a, 32'h0);
        compares++;
        if (rdv !== e) begin
            n_errors++;
            $display("ERROR register %h expected %h got %h", a, e, rdv);
        end
    endtask
    task automatic pchk(logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR output pins expected %h got %h", e, g);
        end
    endtask
    task automatic done(string s);
        $display("test %s finished", s);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        #1 rst = 1'h1;
        void'($urandom(21));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (i = 0; i < 4; i++)
            chk(ra[i], 32'h0);
        chk(`BISM_OFS_STATUS, 32'h0);
        for (i = 0; i < 12; i++) begin
            d = $urandom;
            bus(1'h1, ra[i % 4], d);
            chk(ra[i % 4], d & rm[i % 4]);
        end
        bus(1'h1, 32'h3fc, 32'hffffffff);
        chk(32'h3fc, 32'h0);
        for (i = 0; i < 4; i++)
            bus(1'h1, ra[i], 32'h0);
        bus(1'h1, `BISM_OFS_STATUS, 32'hffffffff);
        bus(1'h1, `BISM_OFS_VME_SW_STATUS, 32'hffffffff);
        chk(`BISM_OFS_STATUS, 32'h0);
        done("registers");
        // Each source: routed, latched, cleared with source still high, then masked
        for (i = 0; i < 7; i++) begin
            p = (i == 4 || i == 6) ? 0 : $urandom_range(i == 5 ? 1 : 7);
            b = sbit(i);
            bus(1'h1, `BISM_OFS_LOCAL_MASK, 1 << b);
            if (i < 4)
                bus(1'h1, `BISM_OFS_MISC_ROUTING, p << fpos(i));
            if (i == 5)
                bus(1'h1, `BISM_OFS_LEVEL_ROUTING, p);
            src[i] <= 1'h1;
            repeat (4) @(posedge clk);
            pchk(8'h1 << p, pins);
            chk(`BISM_OFS_STATUS, 1 << b);
            bus(1'h1, `BISM_OFS_STATUS, 1 << b);
            chk(`BISM_OFS_STATUS, 32'h0);
            pchk(8'h0, pins);
            src[i] <= 1'h0;
            bus(1'h1, `BISM_OFS_LOCAL_MASK, 32'h0);
            src[i] <= 1'h1;
            repeat (4) @(posedge clk);
            pchk(8'h0, pins);
            chk(`BISM_OFS_STATUS, 1 << b);
            bus(1'h1, `BISM_OFS_STATUS, 1 << b);
            src[i] <= 1'h0;
        end
        done("events");
        // Failure lines: clear refused while the line is still up
        for (i = 0; i < 2; i++) begin
            b = 15 - i;
            bus(1'h1, `BISM_OFS_LOCAL_MASK, 1 << b);
            bus(1'h1, `BISM_OFS_MISC_ROUTING, (5 - i) << (28 - 4 * i));
            fl[1 - i] <= 1'h1;
            repeat (8) @(posedge clk);
            pchk(8'h20 >> i, pins);
            bus(1'h1, `BISM_OFS_STATUS, 1 << b);
            chk(`BISM_OFS_STATUS, 1 << b);
            fl[1 - i] <= 1'h0;
            repeat (8) @(posedge clk);
            bus(1'h1, `BISM_OFS_STATUS, 1 << b);
            chk(`BISM_OFS_STATUS, 32'h0);
        end
        done("failure lines");
        bus(1'h1, `BISM_OFS_LOCAL_MASK, 32'h0);
        for (k = 0; k < 8; k++) begin
            b = k ? 24 + k : 12;
            bus(1'h1, `BISM_OFS_VME_ENABLE, 1 << b);
            repeat (3) @(posedge clk);
            pchk(8'h1 << k, {sw_lv, software_interrupt});
            bus(1'h1, `BISM_OFS_VME_ENABLE, 32'h0);
            repeat (3) @(posedge clk);
            pchk(8'h0, {sw_lv, software_interrupt});
            chk(`BISM_OFS_VME_SW_STATUS, 1 << b);
            bus(1'h1, `BISM_OFS_VME_SW_STATUS, 1 << b);
        end
        done("software levels");
        // Level lines served by the far side, fast then slow; kept on pins 0 and 1
        for (i = 0; i < 2; i++) begin
            k = i ? 2 : 5;
            slow <= i[0];
            bus(1'h1, `BISM_OFS_LOCAL_MASK, 1 << k);
            bus(1'h1, `BISM_OFS_LEVEL_ROUTING, (1 - i) << (4 * k));
            raise[k] <= 1'h1;
            @(posedge clk);
            raise[k] <= 1'h0;
            t = 0;
            while (pins === 8'h0 && t < 60) begin
                @(posedge clk);
                t++;
            end
            repeat (2) @(posedge clk);
            pchk(8'h2 >> i, pins);
            chk(`BISM_OFS_STATUS, 1 << k);
            bus(1'h1, `BISM_OFS_STATUS, 1 << k);
        end
        done("level lines");
        // Clock enable low: an event rising meanwhile is held off until run
        bus(1'h1, `BISM_OFS_LOCAL_MASK, 32'h100);
        ce <= 1'h0;
        src[0] <= 1'h1;
        repeat (6) @(posedge clk);
        pchk(8'h0, pins);
        ce <= 1'h1;
        repeat (4) @(posedge clk);
        pchk(8'h1, pins);
        chk(`BISM_OFS_STATUS, 32'h100);
        bus(1'h1, `BISM_OFS_STATUS, 32'h100);
        src[0] <= 1'h0;
        done("clock enable");
        final_report;
    end
    // Hang guard, far beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report;
    end
endmodule

// ### verification/bism_vme_model.sv
/*
 * Far-side model: interrupters on the level lines and the acknowledge cycle.
 * Assumes the bench pulses raise; lines are released once acknowledged.
 */
`timescale 1ns/10ps
module bism_vme_model (
    input wire clk,
    input wire rst,
    input wire [7:1] raise,
    input wire slow,
    input wire [7:1] acknowledge_request,
    output logic [7:1] acknowledge_done,
    output logic [7:1] vme_request_levels
);
    logic [3:0] wait_cnt;
    int lvl;
    // Serve the highest requested level; slow mode mimics a busy bus
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            acknowledge_done <= 7'h0;
            vme_request_levels <= 7'h0;
        end else begin
            acknowledge_done <= 7'h0;
            vme_request_levels <= vme_request_levels | raise;
            if (acknowledge_request == 7'h0 || acknowledge_done != 7'h0)
                wait_cnt <= 4'h0;
            else if (wait_cnt != (slow ? 4'h9 : 4'h1))
                wait_cnt <= wait_cnt + 4'h1;
            else begin
                wait_cnt <= 4'h0;
                for (int k = 1; k < 8; k++)
                    if (acknowledge_request[k])
                        lvl = k;
                acknowledge_done[lvl] <= 1'h1;
                vme_request_levels[lvl] <= 1'h0;  // Interrupter lets go once served
            end
        end
    end
endmodule
